// [scp_cfg.sv]
/*
  Configuration fields of a Hall sensor die: die address, filter
  corners, output clamp levels, with the filters and clamp stage.
  Assumes a classic Wishbone master and synchronous sample inputs.
*/
// What this block does
// - Die address bits 22, 23 of word 0x02
// - Device address is high times two plus low
// - Responses selected by the programmed device address
// - Dual die: die one 0, die two 1
// - Single die resets to address 0
// - Calibration corner code in word 0x03 bits 21:19
// - Calibration corner table, codes 4-7 give 16 Hz
// - Coil self-test time ignores calibration corner
// - Lower calibration corner lengthens compensation response
// - Signal corner code in word 0x03 bits 18:16
// - Inverted upper clamp in word 0x08 bits 11:0
// - Upper code 0 is highest, 0xfff lowest
// - Lower clamp in bits 23:12, 0 lowest
`timescale 1ns/10ps
module scp_cfg #(
  parameter bit DUAL_DIE = 1'b1,
  parameter int DIE_NUM = 1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Shared-bus response selection
  input wire logic i_query_valid,
  input wire logic [1:0] i_query_addr,
  output logic o_resp_sel,
  // Signal path
  input wire logic [11:0] i_mag_sample,
  input wire logic [11:0] i_cal_sample,
  input wire logic i_comp_en,
  output logic [11:0] o_out,
  // Coil self-test
  input wire logic i_self_test_start,
  output logic o_self_test_busy,
  output logic o_self_test_done,
  // Decoded settings
  output logic [1:0] o_dev_addr,
  output logic [10:0] o_calib_corner_chz,
  output logic [12:0] o_signal_corner_hz,
  output logic [11:0] o_clamp_hi,
  output logic [11:0] o_clamp_lo
);
  // ==========================================================
  // Reset value of the die address word
  localparam logic [31:0] DIE_RST = (DUAL_DIE && DIE_NUM == 2) ? 32'h0040_0000 : 32'h0000_0000;
  localparam logic [1:0] DEV_RST = DIE_RST[scp_pkg::DIE_HI_BIT:scp_pkg::DIE_LO_BIT];

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } scp_coil_type;

  logic [31:0] die_r;          // Die address word
  logic [31:0] bw_r;           // Filter bandwidth word
  logic [31:0] clamp_r;        // Output clamp word
  logic ack_r;                 // Bus acknowledge
  logic [31:0] rdat_r;         // Read data
  logic [31:0] rdat_nxt;
  logic [31:0] be;             // Byte enables as a bit mask
  logic wr_now;                // Write takes effect this edge
  logic [5:0] idx;             // Word index
  logic [2:0] cal_code;
  logic [2:0] sig_code;
  logic [11:0] clh_code;
  logic [11:0] cll_code;
  logic [1:0] dev_addr;
  logic [7:0] tick_cnt_r;      // Sample rate divider
  logic tick;                  // One-cycle sample enable
  logic [11:0] mag_y;
  logic [11:0] cal_y;
  logic signed [13:0] proc;    // Compensated sample
  logic [11:0] sat;
  logic [11:0] hi;
  logic [11:0] out_nxt;
  scp_coil_type coil_r;
  logic [11:0] coil_cnt_r;

  // ==========================================================
  // Bus decode
  assign idx = i_wb_adr[7:2];
  assign wr_now = i_wb_cyc && i_wb_stb && i_wb_we && ack_r;
  assign be = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  // Read mux; unmapped words read as zero but still acknowledge
  always_comb begin
    if (idx == scp_pkg::IDX_DIE) begin
      rdat_nxt = die_r;
    end else if (idx == scp_pkg::IDX_BW) begin
      rdat_nxt = bw_r;
    end else if (idx == scp_pkg::IDX_CLAMP) begin
      rdat_nxt = clamp_r;
    end else if (idx == scp_pkg::IDX_STAT) begin
      rdat_nxt = {4'h0, o_out, 7'h00, o_self_test_busy, sig_code, cal_code, dev_addr};
    end else begin
      rdat_nxt = 32'h0000_0000;
    end
  end

  // Acknowledge one cycle after the request, then drop for a cycle
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= i_wb_cyc && i_wb_stb && !ack_r;
      if (i_wb_cyc && i_wb_stb && !ack_r) begin
        rdat_r <= rdat_nxt;
      end
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;

  // ==========================================================
  // Configuration words; writes land on the edge that samples ack
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      die_r <= DIE_RST;
      bw_r <= scp_pkg::BW_RST;
      clamp_r <= scp_pkg::CLAMP_RST;
    end else if (wr_now) begin
      if (idx == scp_pkg::IDX_DIE) begin
        die_r <= (die_r & ~(be & scp_pkg::DIE_MASK)) | (i_wb_dat & be & scp_pkg::DIE_MASK);
      end else if (idx == scp_pkg::IDX_BW) begin
        bw_r <= (bw_r & ~(be & scp_pkg::BW_MASK)) | (i_wb_dat & be & scp_pkg::BW_MASK);
      end else if (idx == scp_pkg::IDX_CLAMP) begin
        clamp_r <= (clamp_r & ~(be & scp_pkg::CLAMP_MASK)) | (i_wb_dat & be & scp_pkg::CLAMP_MASK);
      end
    end
  end

  // ==========================================================
  // Field extraction
  assign dev_addr = {die_r[scp_pkg::DIE_HI_BIT], die_r[scp_pkg::DIE_LO_BIT]};
  assign cal_code = bw_r[scp_pkg::CAL_LSB+2:scp_pkg::CAL_LSB];
  assign sig_code = bw_r[scp_pkg::SIG_LSB+2:scp_pkg::SIG_LSB];
  assign clh_code = clamp_r[scp_pkg::CLH_LSB+11:scp_pkg::CLH_LSB];
  assign cll_code = clamp_r[scp_pkg::CLL_LSB+11:scp_pkg::CLL_LSB];
  assign hi = ~clh_code;

  // Decoded settings held in flip-flops for the analog side
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dev_addr <= DEV_RST;
      o_calib_corner_chz <= 11'h008;
      o_signal_corner_hz <= 13'h0028;
      o_clamp_hi <= 12'hfff;
      o_clamp_lo <= 12'h000;
    end else begin
      o_dev_addr <= dev_addr;
      o_calib_corner_chz <= scp_pkg::cal_corner_chz(cal_code);
      o_signal_corner_hz <= scp_pkg::sig_corner_hz(sig_code);
      o_clamp_hi <= hi;
      o_clamp_lo <= cll_code;
    end
  end

  // ==========================================================
  // Response selection: only our own address answers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_resp_sel <= 1'b0;
    end else begin
      o_resp_sel <= i_query_valid && (i_query_addr == dev_addr);
    end
  end

  // ==========================================================
  // Sample rate divider
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_r <= 8'h00;
    end else if (tick) begin
      tick_cnt_r <= 8'h00;
    end else begin
      tick_cnt_r <= tick_cnt_r + 8'h01;
    end
  end

  assign tick = (tick_cnt_r == 8'(scp_pkg::SAMPLE_CYC - 1));

  // ==========================================================
  // Filters; the slow calibration corner trades noise for settling
  scp_iir #(.W(12)) u_mag_iir (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_en(tick),
    .i_shift(scp_pkg::sig_shift(sig_code)),
    .i_x(i_mag_sample),
    .o_y(mag_y)
  );

  scp_iir #(.W(12)) u_cal_iir (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_en(tick),
    .i_shift(scp_pkg::cal_shift(cal_code)),
    .i_x(i_cal_sample),
    .o_y(cal_y)
  );

  // ==========================================================
  // Compensation, range saturation and clamp; upper wins on overlap
  always_comb begin
    proc = $signed({2'b00, mag_y});
    if (i_comp_en) begin
      proc = proc + $signed({2'b00, cal_y}) - $signed({2'b00, scp_pkg::CAL_MID});
    end
    if (proc < 0) begin
      sat = 12'h000;
    end else if (proc > 14'sh0fff) begin
      sat = 12'hfff;
    end else begin
      sat = proc[11:0];
    end
    // Lower bound first, then upper, so the upper level wins on overlap
    if (sat < cll_code) begin
      out_nxt = cll_code;
    end else begin
      out_nxt = sat;
    end
    if (out_nxt > hi) begin
      out_nxt = hi;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_out <= 12'h000;
    end else begin
      o_out <= out_nxt;
    end
  end

  // ==========================================================
  // Coil self-test: fixed length, no term from the filter codes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      coil_r <= ST_IDLE;
      coil_cnt_r <= 12'h000;
      o_self_test_done <= 1'b0;
    end else begin
      o_self_test_done <= 1'b0;
      case (coil_r)
        ST_IDLE: begin
          if (i_self_test_start) begin
            coil_r <= ST_RUN;
            coil_cnt_r <= 12'h000;
          end
        end
        ST_RUN: begin
          if (coil_cnt_r == 12'(scp_pkg::COIL_CYC - 1)) begin
            coil_r <= ST_IDLE;
            o_self_test_done <= 1'b1;
          end else begin
            coil_cnt_r <= coil_cnt_r + 12'h001;
          end
        end
        default: begin
          coil_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_self_test_busy = (coil_r == ST_RUN);

  // ==========================================================
  // Checks
  logic [11:0] busy_len_r; // Counts busy cycles for the length check
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_len_r <= 12'h000;
    end else if (o_self_test_busy) begin
      busy_len_r <= busy_len_r + 12'h001;
    end else begin
      busy_len_r <= 12'h000;
    end
  end

  bus_ack_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack late");
  ack_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held");
  die_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr_now && idx == scp_pkg::IDX_DIE && i_wb_sel[2] |=> ##1 o_dev_addr == $past(i_wb_dat[23:22], 2))
    else $error("die address not stored");
  die_reset_a: assert property (@(posedge i_ref_clk)
    $fell(i_rst) |-> o_dev_addr == DEV_RST)
    else $error("die address reset wrong");
  resp_sel_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_query_valid && i_query_addr != dev_addr |=> !o_resp_sel)
    else $error("foreign address answered");
  cal_corner_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    cal_code[2] |=> o_calib_corner_chz == 11'h640)
    else $error("calibration corner wrong");
  sig_corner_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    sig_code == 3'h3 |=> o_signal_corner_hz == 13'h0bb8)
    else $error("signal corner wrong");
  coil_time_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(o_self_test_busy) |-> $past(busy_len_r) == 12'(scp_pkg::COIL_CYC - 1))
    else $error("self-test length wrong");
  clamp_hi_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ##1 o_out <= $past(hi))
    else $error("output above upper clamp");
  clamp_lo_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    cll_code <= hi |=> o_out >= $past(cll_code))
    else $error("output below lower clamp");
  // Positive side of the select, decoded tables and the done pulse
  resp_hit_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_query_valid && i_query_addr == dev_addr |=> o_resp_sel)
    else $error("own address not answered");
  sig_wide_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    sig_code[2] |=> o_signal_corner_hz == 13'h1ce8)
    else $error("signal corner wrong for wide codes");
  clamp_inv_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    1'b1 |=> o_clamp_hi == ~$past(clh_code))
    else $error("upper clamp not inverted");
  clamp_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    1'b1 |=> o_clamp_lo == $past(cll_code))
    else $error("lower clamp level wrong");
  coil_done_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(o_self_test_busy) |-> o_self_test_done)
    else $error("self-test done missing");

  die_wr_c: cover property (@(posedge i_ref_clk) wr_now && idx == scp_pkg::IDX_DIE);
  resp_c: cover property (@(posedge i_ref_clk) o_resp_sel);
  coil_c: cover property (@(posedge i_ref_clk) o_self_test_done);
  clamp_c: cover property (@(posedge i_ref_clk) sat > hi);
endmodule : scp_cfg

// [scp_pkg.sv]
/*
  Constants for the sensor parameter configuration block: register
  indices, field positions, reset values, corner tables and timing.
  Assumes a 20 MHz reference clock and a 32-bit classic Wishbone bus.
*/
package scp_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_DIE = 6'h02;   // Die address word
  localparam logic [5:0] IDX_BW = 6'h03;    // Filter bandwidth word
  localparam logic [5:0] IDX_CLAMP = 6'h08; // Output clamp word
  localparam logic [5:0] IDX_STAT = 6'h0a;  // Read-only status word
  // ==========================================================
  // Field positions
  localparam int DIE_LO_BIT = 22;
  localparam int DIE_HI_BIT = 23;
  localparam int CAL_LSB = 19;
  localparam int SIG_LSB = 16;
  localparam int CLH_LSB = 0;
  localparam int CLL_LSB = 12;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_OUT_LSB = 16;
  // Writable bits per word; all other bits read as zero
  localparam logic [31:0] DIE_MASK = 32'h00c0_0000;
  localparam logic [31:0] BW_MASK = 32'h003f_0000;
  localparam logic [31:0] CLAMP_MASK = 32'h00ff_ffff;
  // ==========================================================
  // Reset values
  localparam logic [31:0] BW_RST = 32'h0000_0000;
  localparam logic [31:0] CLAMP_RST = 32'h0000_0000;
  localparam logic [11:0] CAL_MID = 12'h800;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SAMPLE_PERIOD_NS = 10000;
  localparam int SAMPLE_CYC = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COIL_TEST_NS = 100000;
  localparam int COIL_CYC = (COIL_TEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Corner tables: calibration path in centihertz, signal path in hertz
  function automatic logic [10:0] cal_corner_chz(input logic [2:0] code);
    case (code)
      3'h0: cal_corner_chz = 11'h008;
      3'h1: cal_corner_chz = 11'h01e;
      3'h2: cal_corner_chz = 11'h07d;
      3'h3: cal_corner_chz = 11'h190;
      default: cal_corner_chz = 11'h640;
    endcase
  endfunction : cal_corner_chz

  function automatic logic [12:0] sig_corner_hz(input logic [2:0] code);
    case (code)
      3'h0: sig_corner_hz = 13'h0028;
      3'h1: sig_corner_hz = 13'h00a0;
      3'h2: sig_corner_hz = 13'h02a8;
      3'h3: sig_corner_hz = 13'h0bb8;
      default: sig_corner_hz = 13'h1ce8;
    endcase
  endfunction : sig_corner_hz

  // Filter shift per code; a larger shift is a lower corner
  function automatic logic [3:0] cal_shift(input logic [2:0] code);
    case (code)
      3'h0: cal_shift = 4'hf;
      3'h1: cal_shift = 4'hd;
      3'h2: cal_shift = 4'hb;
      3'h3: cal_shift = 4'h9;
      default: cal_shift = 4'h7;
    endcase
  endfunction : cal_shift

  function automatic logic [3:0] sig_shift(input logic [2:0] code);
    case (code)
      3'h0: sig_shift = 4'h6;
      3'h1: sig_shift = 4'h4;
      3'h2: sig_shift = 4'h2;
      3'h3: sig_shift = 4'h1;
      default: sig_shift = 4'h0;
    endcase
  endfunction : sig_shift
endpackage : scp_pkg

// [scp_iir.sv]
/*
  First-order low-pass filter with a programmable shift.
  Assumes a one-cycle update enable from the owning block.
*/
`timescale 1ns/10ps
module scp_iir #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Sample stream
  input wire logic i_en,
  input wire logic [3:0] i_shift,
  input wire logic [W-1:0] i_x,
  output logic [W-1:0] o_y
);
  // ==========================================================
  // Accumulator with 16 fraction bits
  logic [W+15:0] acc_r;
  logic signed [W+16:0] diff;
  logic signed [W+16:0] step;

  // Distance to the new sample, scaled by the shift
  always_comb begin
    diff = $signed({1'b0, i_x, 16'h0000}) - $signed({1'b0, acc_r});
    step = diff >>> i_shift;
  end

  // A larger shift settles more slowly but averages more noise
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_r <= '0;
    end else if (i_en) begin
      acc_r <= acc_r + step[W+15:0];
    end
  end

  assign o_y = acc_r[W+15:16];
endmodule : scp_iir

// [scp_ctrl_model.sv]
/*
  Controller model on the shared sensor output bus: sends address
  queries and reports whether the die selected itself.
  Assumes the bench clock and a registered response select.
*/
`timescale 1ns/10ps
module scp_ctrl_model (
  // Clock
  input wire logic i_ref_clk,
  // Query bus
  input wire logic i_resp_sel,
  output logic o_query_valid,
  output logic [1:0] o_query_addr
);
  // ==========================================================
  // Idle state of the query bus
  initial begin
    o_query_valid = 1'h0;
    o_query_addr = 2'h0;
  end

  // ==========================================================
  // One query; the select is read one cycle after it is taken
  task automatic query(input logic [1:0] a, output logic hit);
    @(posedge i_ref_clk);
    o_query_valid <= 1'h1;
    o_query_addr <= a;
    @(posedge i_ref_clk);
    o_query_valid <= 1'h0;
    // Released address shows the inverse, so a stale value never matches
    o_query_addr <= ~a;
    @(posedge i_ref_clk);
    hit = i_resp_sel;
  endtask : query
endmodule : scp_ctrl_model

// [tb_scp_cfg.sv]
/*
  Self-checking bench for the configuration block: register model,
  decoded settings, response select, self-test timing and clamping.
  Assumes a dual-die build where this die is the second one.
*/
`timescale 1ns/10ps
module tb_scp_cfg;
  // ==========================================================
  // Signals
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, qv, rsel, busy, done;
  logic cen = 1'h0; // Compensation path left off: output must equal the clamped raw input
  logic st = 1'h0;
  logic [1:0] qa, dev;
  logic [11:0] mag = 12'h000;
  logic [11:0] cal = 12'h800;
  logic [11:0] outv, hi, lo;
  logic [10:0] cchz;
  logic [12:0] shz;
  logic hit;
  logic [31:0] sq; // Status word as read back
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] mdl [int]; // Bench copy of the register words
  int cal_t [8] = '{8, 30, 125, 400, 1600, 1600, 1600, 1600};
  int sig_t [8] = '{40, 160, 680, 3000, 7400, 7400, 7400, 7400};
  logic [11:0] cu [2] = '{12'hc00, 12'hf00}; // Upper codes for clamp runs
  logic [11:0] cl [2] = '{12'h100, 12'h200}; // Second pair crosses over
  logic [11:0] xs [3] = '{12'hfff, 12'h000, 12'h180};

  // Clock: 50 ns period
  always #(scp_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  // ==========================================================
  // Design and controller model
  scp_cfg #(.DUAL_DIE(1'h1), .DIE_NUM(2)) i_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_query_valid(qv), .i_query_addr(qa), .o_resp_sel(rsel),
    .i_mag_sample(mag), .i_cal_sample(cal), .i_comp_en(cen), .o_out(outv),
    .i_self_test_start(st), .o_self_test_busy(busy), .o_self_test_done(done),
    .o_dev_addr(dev), .o_calib_corner_chz(cchz), .o_signal_corner_hz(shz),
    .o_clamp_hi(hi), .o_clamp_lo(lo)
  );
  scp_ctrl_model i_ctrl (
    .i_ref_clk(clk), .i_resp_sel(rsel), .o_query_valid(qv), .o_query_addr(qa)
  );

  // ==========================================================
  // Reporting
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // Compare a multi-bit value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Compare a single flag
  task automatic chk_flag(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag

  // ==========================================================
  // Wishbone classic cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [5:0] i, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {i, 2'h0};
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    if (ack !== 1'h1) begin
      err_count++;
      wrap_up();
    end
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    wdat <= ~d;
  endtask : wb

  // Writable bits of each word; unmapped words hold nothing
  function automatic logic [31:0] msk(input logic [5:0] i);
    case (i)
      scp_pkg::IDX_DIE: return scp_pkg::DIE_MASK;
      scp_pkg::IDX_BW: return scp_pkg::BW_MASK;
      scp_pkg::IDX_CLAMP: return scp_pkg::CLAMP_MASK;
      default: return 32'h0;
    endcase
  endfunction : msk

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, i, d, q);
    mdl[i] = d & msk(i);
  endtask : wr

  task automatic rd(input logic [5:0] i);
    logic [31:0] q;
    wb(1'h0, i, 32'h0, q);
    chk("read data", mdl.exists(i) ? mdl[i] : 32'h0, q);
  endtask : rd

  // Saturation model: lower bound first so the upper bound wins
  function automatic logic [11:0] clampm(input logic [11:0] x, input logic [11:0] u,
                                         input logic [11:0] l);
    logic [11:0] y;
    y = (x < l) ? l : x;
    return (y > ~u) ? ~u : y;
  endfunction : clampm

  // Coil self-test: busy must last a fixed count, then one done pulse
  task automatic coil();
    int n = 0;
    @(posedge clk);
    st <= 1'h1;
    @(posedge clk);
    st <= 1'h0;
    do begin
      @(posedge clk);
      n++;
    end while (busy === 1'h1 && n < 5000);
    chk("busy cycles", scp_pkg::COIL_CYC, n - 1);
    chk_flag("done", 1'h1, done);
    if (n >= 5000) wrap_up();
  endtask : coil

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(72399));
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk("dev_addr", 32'h1, dev);
    chk("calib corner", 32'h8, cchz);
    chk("signal corner", 32'h28, shz);
    chk("clamp hi", 32'hfff, hi);
    chk("clamp lo", 32'h0, lo);
    mdl[2] = 32'h0040_0000;
    mdl[3] = 32'h0;
    mdl[8] = 32'h0;
    rd(6'h02);
    rd(6'h03);
    rd(6'h08);
    $display("test reset done");
    // Each address in turn; a real bus gives each sensor a distinct one
    for (int a = 0; a < 4; a++) begin
      wr(6'h02, ($urandom & 32'hff3f_ffff) | (a << 22));
      repeat (2) @(posedge clk);
      chk("dev_addr", a, dev);
      rd(6'h02);
      for (int k = 0; k < 4; k++) begin
        i_ctrl.query(k[1:0], hit);
        chk_flag("resp_sel", k == a, hit);
      end
    end
    $display("test address done");
    for (int c = 0; c < 8; c++) begin
      wr(6'h03, ($urandom & 32'hffc0_ffff) | (c << 19) | ((7 - c) << 16));
      repeat (2) @(posedge clk);
      chk("calib corner", cal_t[c], cchz);
      chk("signal corner", sig_t[7 - c], shz);
      rd(6'h03);
    end
    $display("test corners done");
    wr(6'h03, 32'h0);
    coil();
    wr(6'h03, 32'h0038_0000);
    coil();
    $display("test self-test done");
    for (int k = 0; k < 3; k++) begin
      logic [11:0] u;
      logic [11:0] l;
      u = (k == 0) ? 12'h000 : (k == 1) ? 12'hfff : 12'($urandom);
      l = 12'($urandom);
      wr(6'h08, {8'($urandom), l, u});
      repeat (2) @(posedge clk);
      chk("clamp hi", 12'(~u), hi);
      chk("clamp lo", l, lo);
      rd(6'h08);
    end
    wr(6'h3f, 32'hffff_ffff);
    rd(6'h3f);
    $display("test clamp words done");
    wr(6'h03, 32'h0007_0000);
    for (int p = 0; p < 2; p++) begin
      wr(6'h08, {8'h00, cl[p], cu[p]});
      foreach (xs[j]) begin
        @(posedge clk);
        mag <= xs[j];
        cal <= 12'($urandom);
        repeat (1000) @(posedge clk);
        chk("out", clampm(xs[j], cu[p], cl[p]), outv);
        // Status: address 3, calibration code 0, signal code 7, idle
        wb(1'h0, scp_pkg::IDX_STAT, 32'h0, sq);
        chk("status", {4'h0, clampm(xs[j], cu[p], cl[p]), 16'h00e3}, sq);
      end
    end
    $display("test clamp stage done");
    wrap_up();
  end
endmodule : tb_scp_cfg
